// ### src/adc_conversion_control.sv
// Converter control block: APB registers, conversion sequencing, clock choice and division.
// Assumes the analog core shares REF_CLK_I and returns a one-cycle done with its raw code.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control
    import adc_ctrl_pkg::*;
(
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_N_I,
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [7:0]       PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic      [31:0]      PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    input  wire logic             STOP_MODE_I,
    input  wire logic             HW_TRIGGER_I,
    input  wire logic             ALT_CLK_I,
    input  wire logic             ASYNC_CLK_I,
    input  wire logic             CORE_DONE_I,
    input  wire logic [RAW_W-1:0] CORE_RAW_I,
    output logic      [4:0]       CORE_CHANNEL_O,
    output logic                  CORE_SAMPLE_O,
    output logic                  CORE_CONVERT_O,
    output logic                  CORE_TEN_BIT_O,
    output logic                  CONV_CLK_EN_O,
    output logic                  ASYNC_OSC_EN_O,
    output logic                  LOW_POWER_O,
    output logic                  DONE_IRQ_O
);

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;

    function automatic logic [9:0] round_raw(input logic [RAW_W-1:0] raw, input logic ten);
        logic [10:0] sum;
        sum = 11'h0;
        if (ten) begin
            sum = {1'b0, raw[10:1]} + {10'h0, raw[0]};
            round_raw = sum[10] ? 10'h3ff : sum[9:0];
        end else begin
            sum = {3'h0, raw[10:3]} + {10'h0, raw[2]};
            round_raw = sum[8] ? 10'h0ff : {2'h0, sum[7:0]};
        end
    endfunction : round_raw

    // Pins from other domains: two flops, then an edge flop
    logic [2:0] stop_sync_reg;
    logic [2:0] trig_sync_reg;
    logic [2:0] alt_sync_reg;
    logic [2:0] async_sync_reg;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            stop_sync_reg  <= 3'h0;
            trig_sync_reg  <= 3'h0;
            alt_sync_reg   <= 3'h0;
            async_sync_reg <= 3'h0;
        end else begin
            stop_sync_reg  <= {stop_sync_reg[1:0], STOP_MODE_I};
            trig_sync_reg  <= {trig_sync_reg[1:0], HW_TRIGGER_I};
            alt_sync_reg   <= {alt_sync_reg[1:0], ALT_CLK_I};
            async_sync_reg <= {async_sync_reg[1:0], ASYNC_CLK_I};
        end
    end

    logic stop_mode;
    logic trig_edge;
    logic alt_edge;
    logic async_edge;
    assign stop_mode  = stop_sync_reg[1];
    assign trig_edge  = trig_sync_reg[1] & ~trig_sync_reg[2];
    assign alt_edge   = alt_sync_reg[1] & ~alt_sync_reg[2];
    assign async_edge = async_sync_reg[1] & ~async_sync_reg[2];

    // Registers and sequencer state
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  clkcfg_reg;
    logic [7:0]  clkcfg_next;
    logic [9:0]  result_reg;
    logic [9:0]  result_next;
    logic        done_reg;
    logic        done_next;
    logic        irq_reg;
    logic        irq_next;
    logic        cont_reg;
    logic        cont_next;
    conv_state_t state_reg;
    conv_state_t state_next;
    logic [4:0]  smp_cnt_reg;
    logic [4:0]  smp_cnt_next;
    logic        osc_reg;
    logic        osc_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Decoded fields
    logic [4:0] channel;
    logic [1:0] mode;
    logic       async_en;
    logic       sw_mode;
    logic       ten_bit;
    logic [4:0] smp_target;
    assign channel    = ctrl_reg[CHAN_MSB:0];
    assign mode       = clkcfg_reg[MODE_MSB:MODE_LSB];
    assign async_en   = clkcfg_reg[ASYNC_EN_BIT];
    assign sw_mode    = (mode == MODE_SW_8) || (mode == MODE_SW_10);
    assign ten_bit    = (mode != MODE_SW_8);
    assign smp_target = clkcfg_reg[LONG_SMP_BIT] ? SAMPLE_LONG_TICKS
                                                 : SAMPLE_SHORT_TICKS;

    // Source selection and division
    logic src_tick;
    logic conv_tick;
    always_comb begin
        if (async_en) begin
            src_tick = async_edge;
        end else if (clkcfg_reg[INPUT_SEL_BIT]) begin
            src_tick = 1'b1;
        end else begin
            src_tick = alt_edge;
        end
    end

    adc_clock_divider u_divider (
        .clk_i      (REF_CLK_I),
        .rst_n_i    (RST_N_I),
        .run_i      (state_reg != ST_IDLE),
        .src_tick_i (src_tick),
        .div_sel_i  (clkcfg_reg[DIV_MSB:DIV_LSB]),
        .tick_o     (conv_tick)
    );

    // Bus decode; effects land on the completing edge
    logic xfer;
    logic wr_ctrl;
    logic wr_clk;
    logic rd_low;
    logic rd_high;
    logic mapped;
    logic [7:0] wbyte;
    assign xfer    = PSEL_I & PENABLE_I & pready_reg;
    assign mapped  = (PADDR_I == ADDR_STATUS_CONTROL) || (PADDR_I == ADDR_RESULT_HIGH) ||
                     (PADDR_I == ADDR_RESULT_LOW) || (PADDR_I == ADDR_CLOCK_CONFIG);
    assign wr_ctrl = xfer & PWRITE_I & (PADDR_I == ADDR_STATUS_CONTROL);
    assign wr_clk  = xfer & PWRITE_I & (PADDR_I == ADDR_CLOCK_CONFIG);
    assign rd_low  = xfer & ~PWRITE_I & (PADDR_I == ADDR_RESULT_LOW);
    assign rd_high = xfer & ~PWRITE_I & (PADDR_I == ADDR_RESULT_HIGH);
    assign wbyte   = PWDATA_I[7:0];

    // Sequencer control terms
    logic stop_halt;
    logic conv_end;
    logic start;
    assign stop_halt = stop_mode & ~async_en;
    assign conv_end  = (state_reg == ST_CONVERT) & CORE_DONE_I & ~stop_halt;

    always_comb begin
        start = 1'b0;
        if (stop_halt) begin
            start = 1'b0;
        end else if (wr_ctrl) begin
            start = sw_mode && (wbyte[CHAN_MSB:0] != CHANNEL_NONE);
        end else if (mode == MODE_HW_10 && trig_edge && channel != CHANNEL_NONE) begin
            start = 1'b1;
        end else if (conv_end && cont_reg && sw_mode) begin
            start = 1'b1;
        end
    end

    always_comb begin
        state_next   = state_reg;
        smp_cnt_next = smp_cnt_reg;
        if (start) begin
            state_next   = ST_SAMPLE;
            smp_cnt_next = 5'h0;
        end else if (stop_halt || wr_ctrl) begin
            state_next   = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                ST_SAMPLE: begin
                    if (conv_tick) begin
                        if (smp_cnt_reg == smp_target - 5'h1) begin
                            state_next = ST_CONVERT;
                        end
                        smp_cnt_next = smp_cnt_reg + 5'h1;
                    end
                end
                ST_CONVERT: begin
                    if (CORE_DONE_I) begin
                        state_next = ST_IDLE;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        ctrl_next   = ctrl_reg;
        clkcfg_next = clkcfg_reg;
        result_next = result_reg;
        done_next   = done_reg;
        irq_next    = irq_reg;
        cont_next   = cont_reg;
        osc_next    = async_en & (state_next != ST_IDLE);
        if (wr_ctrl) begin
            ctrl_next = {1'b0, wbyte[6:0]};
            done_next = 1'b0;
            irq_next  = 1'b0;
            cont_next = wbyte[CONT_BIT] && (wbyte[CHAN_MSB:0] != CHANNEL_NONE);
        end
        if (wr_clk) begin
            clkcfg_next = wbyte;
            cont_next   = 1'b0;
            osc_next    = wbyte[ASYNC_EN_BIT] & (state_next != ST_IDLE);
        end
        if (stop_halt) begin
            cont_next = 1'b0;
        end
        if (rd_low) begin
            done_next = 1'b0;
        end
        if (rd_low || rd_high) begin
            irq_next = 1'b0;
        end
        // Set wins over any clear in the same cycle
        if (conv_end) begin
            result_next = round_raw(CORE_RAW_I, ten_bit);
            done_next   = 1'b1;
            irq_next    = ctrl_reg[IRQ_EN_BIT];
        end
    end

    // APB: one wait state, so the answer comes in the second access cycle
    always_comb begin
        pready_next  = PSEL_I & PENABLE_I & ~pready_reg;
        pslverr_next = PSEL_I & PENABLE_I & ~pready_reg & ~mapped;
        prdata_next  = 32'h0;
        if (PSEL_I && PENABLE_I && !pready_reg && !PWRITE_I) begin
            case (PADDR_I)
                ADDR_STATUS_CONTROL: prdata_next = {24'h0, done_reg, ctrl_reg[6:0]};
                ADDR_RESULT_HIGH:    prdata_next = {30'h0, result_reg[9:8]};
                ADDR_RESULT_LOW:     prdata_next = {24'h0, result_reg[7:0]};
                ADDR_CLOCK_CONFIG:   prdata_next = {24'h0, clkcfg_reg};
                default:             prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            ctrl_reg    <= STATUS_CONTROL_RESET;
            clkcfg_reg  <= CLOCK_CONFIG_RESET;
            result_reg  <= 10'h0;
            done_reg    <= 1'b0;
            irq_reg     <= 1'b0;
            cont_reg    <= 1'b0;
            state_reg   <= ST_IDLE;
            smp_cnt_reg <= 5'h0;
            osc_reg     <= 1'b0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            ctrl_reg    <= ctrl_next;
            clkcfg_reg  <= clkcfg_next;
            result_reg  <= result_next;
            done_reg    <= done_next;
            irq_reg     <= irq_next;
            cont_reg    <= cont_next;
            state_reg   <= state_next;
            smp_cnt_reg <= smp_cnt_next;
            osc_reg     <= osc_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // Core-facing outputs registered to keep them glitch free
    logic [4:0] chan_out_reg;
    logic       smp_out_reg;
    logic       cnv_out_reg;
    logic       ten_out_reg;
    logic       clk_en_reg;
    logic       lp_out_reg;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            chan_out_reg <= CHANNEL_NONE;
            smp_out_reg  <= 1'b0;
            cnv_out_reg  <= 1'b0;
            ten_out_reg  <= 1'b0;
            clk_en_reg   <= 1'b0;
            lp_out_reg   <= 1'b0;
        end else begin
            chan_out_reg <= channel;
            smp_out_reg  <= (state_reg == ST_SAMPLE);
            cnv_out_reg  <= (state_reg == ST_CONVERT);
            ten_out_reg  <= ten_bit;
            clk_en_reg   <= conv_tick;
            lp_out_reg   <= clkcfg_reg[LOW_POWER_BIT];
        end
    end

    assign PRDATA_O       = prdata_reg;
    assign PREADY_O       = pready_reg;
    assign PSLVERR_O      = pslverr_reg;
    assign CORE_CHANNEL_O = chan_out_reg;
    assign CORE_SAMPLE_O  = smp_out_reg;
    assign CORE_CONVERT_O = cnv_out_reg;
    assign CORE_TEN_BIT_O = ten_out_reg;
    assign CONV_CLK_EN_O  = clk_en_reg;
    assign ASYNC_OSC_EN_O = osc_reg;
    assign LOW_POWER_O    = lp_out_reg;
    assign DONE_IRQ_O     = irq_reg;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    AST_WRITE_STARTS: assert property (wr_ctrl && !stop_halt && sw_mode &&
        wbyte[CHAN_MSB:0] != CHANNEL_NONE |=> state_reg == ST_SAMPLE && smp_cnt_reg == 5'h0)
        else $error("status write did not start a conversion");
    AST_DONE_SET: assert property (conv_end |=> done_reg)
        else $error("done flag not set at conversion end");
    AST_DONE_CLEAR: assert property ((wr_ctrl || rd_low) && !conv_end |=> !done_reg)
        else $error("done flag not cleared");
    AST_IRQ_SET: assert property (conv_end && ctrl_reg[IRQ_EN_BIT] |=> DONE_IRQ_O)
        else $error("interrupt missing at conversion end");
    AST_CONT_RESTART: assert property (conv_end && cont_reg && sw_mode && !wr_ctrl
        && !wr_clk |=> state_reg == ST_SAMPLE ##1 smp_out_reg)
        else $error("continuous conversion did not restart");
    AST_CLK_WRITE_STOPS: assert property (wr_clk |=> !cont_reg)
        else $error("clock write left continuous running");
    AST_STOP_HALTS: assert property (stop_halt |=> state_reg == ST_IDLE && !cont_reg)
        else $error("conversion proceeded in stop mode");
    sequence sample_last_s;
        state_reg == ST_SAMPLE && conv_tick && smp_cnt_reg == smp_target - 5'h1;
    endsequence
    AST_SAMPLE_LEN: assert property (sample_last_s ##0 (!start && !stop_halt && !wr_ctrl)
        |=> state_reg == ST_CONVERT ##1 cnv_out_reg)
        else $error("sample phase length wrong");
    AST_SAMPLE_BOUND: assert property (state_reg == ST_SAMPLE |-> smp_cnt_reg < smp_target)
        else $error("sample counter overran target");
    AST_DIV8: assert property (conv_tick && clkcfg_reg[DIV_MSB:DIV_LSB] == 2'h3 && !async_en
        && clkcfg_reg[INPUT_SEL_BIT] && !wr_clk |=> (!conv_tick)[*7])
        else $error("divide by eight spacing wrong");
    AST_OSC_IDLE: assert property (state_reg == ST_IDLE && !start |=> !ASYNC_OSC_EN_O)
        else $error("async generator running while idle");

endmodule : adc_conversion_control
`default_nettype wire

// ### pkg/adc_ctrl_pkg.sv
// Package for the converter control block: register map, fields, reset values, timing.
// Assumes a 32-bit APB bus with byte addresses and an 11-bit raw result from the core.
package adc_ctrl_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_RESULT_HIGH    = 8'h04;
    localparam logic [7:0] ADDR_RESULT_LOW     = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_CONFIG   = 8'h0c;

    // Reset values
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h1f;
    localparam logic [7:0] CLOCK_CONFIG_RESET   = 8'h00;

    // Status/control fields
    localparam int         DONE_BIT       = 7;
    localparam int         IRQ_EN_BIT     = 6;
    localparam int         CONT_BIT       = 5;
    localparam int         CHAN_MSB       = 4;
    localparam logic [4:0] CHANNEL_NONE   = 5'h1f;

    // Clock config fields
    localparam int         LOW_POWER_BIT  = 7;
    localparam int         DIV_MSB        = 6;
    localparam int         DIV_LSB        = 5;
    localparam int         INPUT_SEL_BIT  = 4;
    localparam int         MODE_MSB       = 3;
    localparam int         MODE_LSB       = 2;
    localparam int         LONG_SMP_BIT   = 1;
    localparam int         ASYNC_EN_BIT   = 0;

    // Mode encodings
    localparam logic [1:0] MODE_SW_8      = 2'h0;
    localparam logic [1:0] MODE_SW_10     = 2'h1;
    localparam logic [1:0] MODE_RESERVED  = 2'h2;
    localparam logic [1:0] MODE_HW_10     = 2'h3;

    // Sample phase in half conversion-clock cycles, rounded up to whole ticks
    localparam int         SAMPLE_SHORT_HALVES = 7;
    localparam int         SAMPLE_LONG_HALVES  = 47;
    localparam logic [4:0] SAMPLE_SHORT_TICKS  = 5'((SAMPLE_SHORT_HALVES + 1) / 2);
    localparam logic [4:0] SAMPLE_LONG_TICKS   = 5'((SAMPLE_LONG_HALVES + 1) / 2);

    localparam int         RAW_W          = 11;

endpackage : adc_ctrl_pkg

// ### src/adc_clock_divider.sv
// Conversion clock divider: turns source ticks into conversion clock enable pulses.
// Assumes src_tick_i is a one-cycle enable on the system clock.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider
    import adc_ctrl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic       src_tick_i,
    input  wire logic [1:0] div_sel_i,
    output logic            tick_o
);

    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic       tick_reg;
    logic       tick_next;
    logic [2:0] last;

    always_comb begin
        last      = 3'((4'h1 << div_sel_i) - 4'h1);
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run_i) begin
            cnt_next = 3'h0;
        end else if (src_tick_i) begin
            if (cnt_reg == last) begin
                cnt_next  = 3'h0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule : adc_clock_divider
`default_nettype wire

// ### bench/adc_core_model.sv
// Analog core model: one done pulse and raw code per conversion.
// Assumes convert_i rises once per conversion; delay_i sets answer time.
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        convert_i,
    input  wire logic [3:0]  delay_i,
    input  wire logic [10:0] code_i,
    output logic             done_o,
    output logic [10:0]      raw_o
);
    logic [3:0] cnt_reg;
    logic       sent_reg;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        raw_o <= ~raw_o;
        // Stale code never stands after done
        if (!rst_n_i || !convert_i) begin
            cnt_reg <= 4'h0;
            sent_reg <= 1'b0;
            if (!rst_n_i) raw_o <= 11'h000;
        end else if (!sent_reg && cnt_reg == delay_i) begin
            done_o <= 1'b1;
            raw_o <= code_i;
            sent_reg <= 1'b1;
        end else if (!sent_reg) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule : adc_core_model
`default_nettype wire

// ### bench/test_adc_conversion_control.sv
// Testbench for the converter control block: APB tasks, directed runs.
// Assumes adc_core_model on the core side and a 40 MHz bus clock.
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control;
    import adc_ctrl_pkg::*;
    localparam logic [7:0] SC = ADDR_STATUS_CONTROL;
    localparam logic [7:0] CK = ADDR_CLOCK_CONFIG;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        stop = 0, trig = 0, alt = 0, aclk = 0, cdone, e;
    logic        pready, pslverr, samp, conv, ten, clken, oscen, lowp, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [10:0] code = 11'h000, craw;
    logic [3:0]  dly = 4'h3;
    logic [4:0]  chan;
    int          err_count = 0, checks_done = 0, dones = 0, n, k;
    int          since = 0, gap = 0, sticks = 0, stot = 0;
    always #12.5 clk = ~clk;
    always #80 alt = ~alt;
    always #110 aclk = oscen ? ~aclk : 1'b0;
    adc_conversion_control adc_conversion_control_i (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .STOP_MODE_I(stop),
        .HW_TRIGGER_I(trig), .ALT_CLK_I(alt), .ASYNC_CLK_I(aclk),
        .CORE_DONE_I(cdone), .CORE_RAW_I(craw), .CORE_CHANNEL_O(chan),
        .CORE_SAMPLE_O(samp), .CORE_CONVERT_O(conv), .CORE_TEN_BIT_O(ten),
        .CONV_CLK_EN_O(clken), .ASYNC_OSC_EN_O(oscen), .LOW_POWER_O(lowp),
        .DONE_IRQ_O(irq));
    adc_core_model adc_core_model_i (.clk_i(clk), .rst_n_i(rst_n), .convert_i(conv),
        .delay_i(dly), .code_i(code), .done_o(cdone), .raw_o(craw));
    // Tick spacing and ticks seen while sampling
    always @(posedge clk) begin
        dones <= dones + int'(cdone === 1'b1);
        since <= (clken === 1'b1) ? 1 : since + 1;
        if (clken === 1'b1) gap <= since;
        sticks <= (samp === 1'b1) ? sticks + int'(clken === 1'b1) : 0;
        if (samp !== 1'b1 && sticks != 0) stot <= sticks;
    end
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    task automatic final_report;
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check("pready", 0, 1);
            final_report();
        end
        @(posedge clk);
    endtask : apb
    task automatic wait_done(input int t);
        n = 0;
        while (dones < t && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) begin
            check("done_wait", 0, 1);
            final_report();
        end
        repeat (2) @(posedge clk);
    endtask : wait_done
    // No further conversion ends once the run has settled; none at all if idle is set
    task automatic quiet(input logic idle);
        int k0;
        k0 = dones;
        repeat (60) @(posedge clk);
        k = dones;
        repeat (60) @(posedge clk);
        check("quiet", dones, k);
        if (idle) check("no_start", k, k0);
    endtask : quiet
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        apb(0, SC, 0); check("status_rst", q, 32'h1f);
        apb(0, CK, 0); check("clock_rst", q, 32'h0);
        check("chan_rst", chan, 32'h1f);
        apb(0, 8'h10, 0); check("unmapped", e, 1);
        apb(1, CK, 32'h10);
        code <= 11'h7fd;
        apb(1, SC, 32'h43);
        wait_done(1);
        check("irq_set", irq, 1);
        check("channel", chan, 32'h3);
        check("eight_bit", ten, 0);
        apb(0, SC, 0); check("done_set", q, 32'hc3);
        apb(0, ADDR_RESULT_HIGH, 0); check("res_h8", q, 0);
        apb(0, ADDR_RESULT_LOW, 0); check("res_l8", q, 32'hff);
        check("irq_clr", irq, 0);
        apb(0, SC, 0); check("done_clr", q, 32'h43);
        code <= 11'h4d3;
        apb(1, CK, 32'h76);
        apb(1, SC, 32'h02);
        wait_done(2);
        check("ten_bit", ten, 1);
        check("long_smp", stot >= 23 && stot <= 25, 1);
        apb(0, ADDR_RESULT_HIGH, 0); check("res_h10", q, 32'h2);
        apb(1, SC, 32'h1f);
        apb(0, SC, 0); check("done_wr", q, 32'h1f);
        quiet(1'b1);
        for (int i = 0; i < 4; i++) begin
            apb(1, CK, 32'h10 | (i << 5));
            apb(1, SC, 32'h01);
            wait_done(dones + 1);
            check("div_gap", gap, 1 << i);
        end
        apb(1, CK, 32'h00);
        apb(1, SC, 32'h01);
        wait_done(dones + 1);
        check("alt_gap", gap >= 6 && gap <= 7, 1);
        dly <= 4'h1;
        apb(1, CK, 32'h10);
        apb(1, SC, 32'h21);
        wait_done(dones + 3);
        apb(1, CK, 32'h10);
        quiet(1'b0);
        apb(1, SC, 32'h21);
        wait_done(dones + 2);
        apb(1, SC, 32'h01);
        quiet(1'b0);
        apb(1, SC, 32'h21);
        wait_done(dones + 1);
        stop <= 1'b1;
        quiet(1'b0);
        stop <= 1'b0;
        quiet(1'b1);
        apb(1, CK, 32'h18);
        apb(1, SC, 32'h01);
        quiet(1'b1);
        apb(1, CK, 32'h1c);
        apb(1, SC, 32'h01);
        quiet(1'b1);
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        trig <= 1'b0;
        wait_done(k + 1);
        apb(1, CK, 32'h81);
        check("osc_idle", oscen, 0);
        stop <= 1'b1;
        apb(1, SC, 32'h01);
        repeat (10) @(posedge clk);
        check("osc_run", oscen, 1);
        check("low_power", lowp, 1);
        wait_done(dones + 1);
        check("osc_off", oscen, 0);
        final_report();
    end
endmodule : test_adc_conversion_control
`default_nettype wire
